// ==== core/fdrl_map.vh ====
`ifndef FDRL_MAP_VH
`define FDRL_MAP_VH
`define FDRL_ADDR_DYN_CTRL 8'h36
`define FDRL_ADDR_DRV1_CFG 8'h5C
`define FDRL_ADDR_DRV2_CFG 8'h5D
`define FDRL_ADDR_DRV3_CFG 8'h5E
`define FDRL_ADDR_ACOU1 8'h62
`define FDRL_ADDR_DRIVE_TWO_STEP_SELECT 8'h63
`define FDRL_RST_VAL 8'h00
`define FDRL_BIT_R2_DYN 7
`define FDRL_BIT_LOC_DYN 6
`define FDRL_BIT_R1_DYN 5
`define FDRL_BIT_ACOU1_EN 3
`define FDRL_BIT_DRIVE_TWO_STEP_SELECT_EN 7
`define FDRL_BIT_DRIVE_THREE_STEP_SELECT_EN 3
`define FDRL_BIT_SLOW 3
`define FDRL_STEP1_HI 2
`define FDRL_STEP1_LO 0
`define FDRL_STEP2_HI 6
`define FDRL_STEP2_LO 4
`define FDRL_STEP3_HI 2
`define FDRL_STEP3_LO 0
`define FDRL_SLOT_MAX 8'hFF
`define FDRL_SLOW_DIV 2'h3
`define FDRL_SLOW_ZERO 2'h0
`define FDRL_SLOW_INC 2'h1
`endif

// ==== core/fdrl_top.v ====
`timescale 1ns/1ps
`include "fdrl_map.vh"
module fdrl_top (
  input wire clk,
  input wire arst_n,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  output reg [7:0] reg_rdata,
  input wire temp_update,
  input wire [7:0] target_duty_one,
  input wire [7:0] target_duty_two,
  input wire [7:0] target_duty_three,
  output wire remote_two_dynamic_enable,
  output wire local_dynamic_enable,
  output wire remote_one_dynamic_enable,
  output reg [7:0] first_fan_drive,
  output reg [7:0] second_fan_drive,
  output reg [7:0] third_fan_drive
);
  reg [7:0] dyn_ctrl_q;
  reg [7:0] cfg1_q;
  reg [7:0] cfg2_q;
  reg [7:0] cfg3_q;
  reg [7:0] acou1_q;
  reg [7:0] drive_two_step_select_q;
  reg [1:0] slow1_q;
  reg [1:0] slow2_q;
  reg [1:0] slow3_q;
  wire [2:0] drive_one_step_select;
  wire [2:0] drive_two_step_select;
  wire [2:0] drive_three_step_select;
  reg [7:0] dyn_ctrl_d;
  reg [7:0] cfg1_d;
  reg [7:0] cfg2_d;
  reg [7:0] cfg3_d;
  reg [7:0] acou1_d;
  reg [7:0] drive_two_step_select_d;
  reg [1:0] slow1_d;
  reg [1:0] slow2_d;
  reg [1:0] slow3_d;
  reg [7:0] drive1_d;
  reg [7:0] drive2_d;
  reg [7:0] drive3_d;
  reg [7:0] rdata_d;
  wire [2:0] reg_sel;

  // register select codes
  localparam [2:0] SEL_NONE = 3'h0;
  localparam [2:0] SEL_DYN = 3'h1;
  localparam [2:0] SEL_CFG1 = 3'h2;
  localparam [2:0] SEL_CFG2 = 3'h3;
  localparam [2:0] SEL_CFG3 = 3'h4;
  localparam [2:0] SEL_ACOU1 = 3'h5;
  localparam [2:0] SEL_DRIVE_TWO_STEP_SELECT = 3'h6;

  // one decode shared by write and read so the two maps cannot drift apart
  function [2:0] addr_select;
    input [7:0] addr;
    begin
      if (addr == `FDRL_ADDR_DYN_CTRL) begin
        addr_select = SEL_DYN;
      end else if (addr == `FDRL_ADDR_DRV1_CFG) begin
        addr_select = SEL_CFG1;
      end else if (addr == `FDRL_ADDR_DRV2_CFG) begin
        addr_select = SEL_CFG2;
      end else if (addr == `FDRL_ADDR_DRV3_CFG) begin
        addr_select = SEL_CFG3;
      end else if (addr == `FDRL_ADDR_ACOU1) begin
        addr_select = SEL_ACOU1;
      end else if (addr == `FDRL_ADDR_DRIVE_TWO_STEP_SELECT) begin
        addr_select = SEL_DRIVE_TWO_STEP_SELECT;
      end else begin
        addr_select = SEL_NONE;
      end
    end
  endfunction

  assign reg_sel = addr_select(reg_addr);

  // ramp step in slots for a 3-bit code
  function [7:0] step_of;
    input [2:0] code;
    begin
      case (code)
        3'h0: step_of = 8'h01;
        3'h1: step_of = 8'h02;
        3'h2: step_of = 8'h03;
        3'h3: step_of = 8'h05;
        3'h4: step_of = 8'h08;
        3'h5: step_of = 8'h0C;
        3'h6: step_of = 8'h18;
        default: step_of = 8'h30;
      endcase
    end
  endfunction

  // one limited move; clamps at the target so no overshoot or wrap
  function [7:0] ramp_next;
    input [7:0] prev;
    input [7:0] tgt;
    input [7:0] step;
    reg [8:0] diff;
    begin
      diff = 9'h000;
      if (tgt > prev) begin
        diff = {1'b0, tgt} - {1'b0, prev};
        if (diff > {1'b0, step}) begin
          ramp_next = prev + step;
        end else begin
          ramp_next = tgt;
        end
      end else if (tgt < prev) begin
        diff = {1'b0, prev} - {1'b0, tgt};
        if (diff > {1'b0, step}) begin
          ramp_next = prev - step;
        end else begin
          ramp_next = tgt;
        end
      end else begin
        ramp_next = prev;
      end
    end
  endfunction

  assign drive_one_step_select = acou1_q[`FDRL_STEP1_HI:`FDRL_STEP1_LO];
  assign drive_two_step_select = drive_two_step_select_q[`FDRL_STEP2_HI:`FDRL_STEP2_LO];
  assign drive_three_step_select = drive_two_step_select_q[`FDRL_STEP3_HI:`FDRL_STEP3_LO];

  // dynamic enables go to the start-temperature logic outside this block
  // remote two enable
  assign remote_two_dynamic_enable = dyn_ctrl_q[`FDRL_BIT_R2_DYN];
  assign local_dynamic_enable = dyn_ctrl_q[`FDRL_BIT_LOC_DYN];
  assign remote_one_dynamic_enable = dyn_ctrl_q[`FDRL_BIT_R1_DYN];
  // adjust is external; cleared bit leaves start temperature alone

  // unmapped addresses fall through and change nothing
  always @* begin
    dyn_ctrl_d = dyn_ctrl_q;
    cfg1_d = cfg1_q;
    cfg2_d = cfg2_q;
    cfg3_d = cfg3_q;
    acou1_d = acou1_q;
    drive_two_step_select_d = drive_two_step_select_q;
    if (reg_wr) begin
      if (reg_sel == SEL_DYN) begin
        dyn_ctrl_d = reg_wdata;
      end else if (reg_sel == SEL_CFG1) begin
        cfg1_d = reg_wdata;
      end else if (reg_sel == SEL_CFG2) begin
        cfg2_d = reg_wdata;
      end else if (reg_sel == SEL_CFG3) begin
        cfg3_d = reg_wdata;
      end else if (reg_sel == SEL_ACOU1) begin
        acou1_d = reg_wdata;
      end else if (reg_sel == SEL_DRIVE_TWO_STEP_SELECT) begin
        drive_two_step_select_d = reg_wdata;
      end
    end
  end

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      dyn_ctrl_q <= `FDRL_RST_VAL;
      cfg1_q <= `FDRL_RST_VAL;
      cfg2_q <= `FDRL_RST_VAL;
      cfg3_q <= `FDRL_RST_VAL;
      acou1_q <= `FDRL_RST_VAL;
      drive_two_step_select_q <= `FDRL_RST_VAL;
    end else begin
      dyn_ctrl_q <= dyn_ctrl_d;
      cfg1_q <= cfg1_d;
      cfg2_q <= cfg2_d;
      cfg3_q <= cfg3_d;
      acou1_q <= acou1_d;
      drive_two_step_select_q <= drive_two_step_select_d;
    end
  end

  // read data sits in a flop and holds between reads; a read beside a write sees the old value
  always @* begin
    rdata_d = reg_rdata;
    if (reg_rd) begin
      if (reg_sel == SEL_DYN) begin
        rdata_d = dyn_ctrl_q;
      end else if (reg_sel == SEL_CFG1) begin
        rdata_d = cfg1_q;
      end else if (reg_sel == SEL_CFG2) begin
        rdata_d = cfg2_q;
      end else if (reg_sel == SEL_CFG3) begin
        rdata_d = cfg3_q;
      end else if (reg_sel == SEL_ACOU1) begin
        rdata_d = acou1_q;
      end else if (reg_sel == SEL_DRIVE_TWO_STEP_SELECT) begin
        rdata_d = drive_two_step_select_q;
      end else begin
        rdata_d = `FDRL_RST_VAL;
      end
    end
  end

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata <= `FDRL_RST_VAL;
    end else begin
      reg_rdata <= rdata_d;
    end
  end

  // slow mode steps only on every fourth update; full-scale time then grows fourfold
  wire slow1_go = ~cfg1_q[`FDRL_BIT_SLOW] | (slow1_q == `FDRL_SLOW_DIV);
  wire slow2_go = ~cfg2_q[`FDRL_BIT_SLOW] | (slow2_q == `FDRL_SLOW_DIV);
  wire slow3_go = ~cfg3_q[`FDRL_BIT_SLOW] | (slow3_q == `FDRL_SLOW_DIV);

  always @* begin
    slow1_d = slow1_q;
    slow2_d = slow2_q;
    slow3_d = slow3_q;
    if (temp_update) begin
      slow1_d = cfg1_q[`FDRL_BIT_SLOW] ? slow1_q + `FDRL_SLOW_INC : `FDRL_SLOW_ZERO;
      slow2_d = cfg2_q[`FDRL_BIT_SLOW] ? slow2_q + `FDRL_SLOW_INC : `FDRL_SLOW_ZERO;
      slow3_d = cfg3_q[`FDRL_BIT_SLOW] ? slow3_q + `FDRL_SLOW_INC : `FDRL_SLOW_ZERO;
    end
  end

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      slow1_q <= `FDRL_SLOW_ZERO;
      slow2_q <= `FDRL_SLOW_ZERO;
      slow3_q <= `FDRL_SLOW_ZERO;
    end else begin
      slow1_q <= slow1_d;
      slow2_q <= slow2_d;
      slow3_q <= slow3_d;
    end
  end

  // next duty of one output on an update pulse
  function [7:0] drive_next;
    input en;
    input go;
    input [7:0] prev;
    input [7:0] tgt;
    input [2:0] code;
    begin
      if (!en) begin
        drive_next = tgt;
      end else if (go) begin
        drive_next = ramp_next(prev, tgt, step_of(code));
      end else begin
        drive_next = prev;
      end
    end
  endfunction

  always @* begin
    drive1_d = first_fan_drive;
    drive2_d = second_fan_drive;
    drive3_d = third_fan_drive;
    if (temp_update) begin
      drive1_d = drive_next(acou1_q[`FDRL_BIT_ACOU1_EN], slow1_go, first_fan_drive, target_duty_one,
        drive_one_step_select);
      drive2_d = drive_next(drive_two_step_select_q[`FDRL_BIT_DRIVE_TWO_STEP_SELECT_EN], slow2_go, second_fan_drive, target_duty_two,
        drive_two_step_select);
      drive3_d = drive_next(drive_two_step_select_q[`FDRL_BIT_DRIVE_THREE_STEP_SELECT_EN], slow3_go, third_fan_drive, target_duty_three,
        drive_three_step_select);
    end
  end

  // ramp time per slot is set by the update cadence; 255 updates at one slot gives about 35 s
  // cadence sets time
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      first_fan_drive <= `FDRL_RST_VAL;
      second_fan_drive <= `FDRL_RST_VAL;
      third_fan_drive <= `FDRL_RST_VAL;
    end else begin
      first_fan_drive <= drive1_d;
      second_fan_drive <= drive2_d;
      third_fan_drive <= drive3_d;
    end
  end
  // 8-bit duty spans 0 to 255 slots
endmodule // fdrl_top

// ==== test/fdrl_fan_model.sv ====
`timescale 1ns/1ps
module fdrl_fan_model (
  input clk,
  input [7:0] duty,
  output fan_on
);
  reg [7:0] slot_q = 8'h00;
  always @(posedge clk) slot_q <= slot_q == 8'hFE ? 8'h00 : slot_q + 8'h01;
  assign fan_on = slot_q < duty;
endmodule // fdrl_fan_model

// ==== test/fdrl_top_properties.sv ====
`timescale 1ns/1ps
module fdrl_chk (
  input clk,
  input arst_n,
  input reg_wr,
  input [7:0] reg_addr,
  input [7:0] reg_wdata,
  input temp_update,
  input [7:0] target_duty_one,
  input remote_two_dynamic_enable,
  input local_dynamic_enable,
  input remote_one_dynamic_enable,
  input [7:0] first_fan_drive,
  input [7:0] second_fan_drive,
  input [7:0] third_fan_drive
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  sequence s_dyn;
    reg_wr && reg_addr == 8'h36;
  endsequence
  AST_R2: assert property (s_dyn |=> remote_two_dynamic_enable == $past(reg_wdata[7])) else $error("r2");
  AST_LT: assert property (s_dyn |=> local_dynamic_enable == $past(reg_wdata[6])) else $error("lt");
  AST_R1: assert property (s_dyn |=> remote_one_dynamic_enable == $past(reg_wdata[5])) else $error("r1");
  AST_H1: assert property (!temp_update |=> $stable(first_fan_drive)) else $error("h1");
  AST_H2: assert property (!temp_update |=> $stable(second_fan_drive)) else $error("h2");
  AST_H3: assert property (!temp_update |=> $stable(third_fan_drive)) else $error("h3");
  AST_UP: assert property (temp_update && first_fan_drive <= target_duty_one |=>
    first_fan_drive <= $past(target_duty_one) && first_fan_drive >= $past(first_fan_drive)) else $error("up");
  AST_DN: assert property (temp_update && first_fan_drive >= target_duty_one |=>
    first_fan_drive >= $past(target_duty_one) && first_fan_drive <= $past(first_fan_drive)) else $error("dn");
endmodule // fdrl_chk
bind fdrl_top fdrl_chk u_chk (.*);

// ==== test/fdrl_top_tb.sv ====
`timescale 1ns/1ps
module fdrl_top_tb;
  reg clk = 1'h0, arst_n = 1'h0, reg_wr = 1'h0, reg_rd = 1'h0, temp_update = 1'h0;
  reg [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, target_duty_one = 8'h00;
  reg [7:0] target_duty_two = 8'h00, target_duty_three = 8'h00, mr [0:255] = '{default: 8'h00};
  reg [7:0] al [0:6] = '{8'h36, 8'h5C, 8'h5D, 8'h5E, 8'h62, 8'h63, 8'h00};
  wire [7:0] reg_rdata, first_fan_drive, second_fan_drive, third_fan_drive;
  wire remote_two_dynamic_enable, local_dynamic_enable, remote_one_dynamic_enable;
  integer st [0:7] = '{1, 2, 3, 5, 8, 12, 24, 48};
  integer m [0:2] = '{0, 0, 0}, n [0:2] = '{0, 0, 0}, bad_count = 0, n_checks = 0, i;
  fdrl_top u_dut (.*);
  fdrl_fan_model u_fan (.clk(clk), .duty(first_fan_drive), .fan_on());
  initial forever #5 clk = ~clk;
  task chk(input string nm, input [23:0] exp, got);
    n_checks = n_checks + 1;
    if (got !== exp) $display("CHECK FAILED %0s %h %h", nm, exp, got);
    if (got !== exp) bad_count = bad_count + 1;
  endtask
  task tally_and_finish;
    $display("checks %0d bad %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // read in the write cycle sees the old value
  task rw(input [7:0] a, d, input we);
    @(posedge clk);
    {reg_wr, reg_rd, reg_addr, reg_wdata} <= {we, 1'h1, a, d};
    @(posedge clk);
    {reg_wr, reg_rd} <= 2'h0;
    @(negedge clk);
    chk("rdata", mr[a], reg_rdata);
    if (we && a != 8'h00) mr[a] = d;
  endtask
  task sc(input integer c, t, input en, input [2:0] k, input sl);
    integer p;
    p = m[c];
    if (!en) m[c] = t;
    else if (!sl || n[c] == 3) m[c] = t > p ? (t - p < st[k] ? t : p + st[k]) : (p - t < st[k] ? t : p - st[k]);
    n[c] = sl ? (n[c] + 1) % 4 : 0;
  endtask
  task upd(input [7:0] a, b, e);
    @(posedge clk);
    {temp_update, target_duty_one, target_duty_two, target_duty_three} <= {1'h1, a, b, e};
    @(posedge clk);
    temp_update <= 1'h0;
    sc(0, a, mr[8'h62][3], mr[8'h62][2:0], mr[8'h5C][3]);
    sc(1, b, mr[8'h63][7], mr[8'h63][6:4], mr[8'h5D][3]);
    sc(2, e, mr[8'h63][3], mr[8'h63][2:0], mr[8'h5E][3]);
    @(negedge clk);
    chk("drives", {m[0][7:0], m[1][7:0], m[2][7:0]},
      {first_fan_drive, second_fan_drive, third_fan_drive});
  endtask
  initial begin
    i = $urandom(25);
    repeat (6) @(posedge clk);
    arst_n <= 1'h1;
    for (i = 0; i < 7; i = i + 1) rw(al[i], 8'h00, 1'h0);
    $display("test 1 done");
    for (i = 0; i < 7; i = i + 1) rw(al[i], $urandom, 1'h1);
    repeat (6) upd($urandom, $urandom, $urandom);
    $display("test 2 done");
    for (i = 0; i < 8; i = i + 1) begin
      rw(8'h62, 8'h08 | i, 1'h1);
      rw(8'h63, 8'h88 | i << 4 | i, 1'h1);
      upd(8'hFF, 8'hFF, 8'hFF);
      repeat (4) upd($urandom, $urandom, $urandom);
    end
    $display("test 3 done");
    for (i = 1; i < 4; i = i + 1) rw(al[i], 8'h08, 1'h1);
    repeat (9) upd($urandom, $urandom, $urandom);
    $display("test 4 done");
    tally_and_finish;
  end
endmodule // fdrl_top_tb
